//--- core/nv_host_ctrl.sv
// host-side access controller for a nonvolatile sram with clock
`timescale 1ns/1ps
`default_nettype none
module nv_host_ctrl
    import nv_host_pkg::*;
#(
    parameter int unsigned RECALL_WAIT = RECALL_CYC,
    parameter int unsigned STORE_WAIT  = STORE_CYC,
    parameter int unsigned SOFT_WAIT   = SOFT_SEQ_CYC,
    parameter int unsigned SWREC_WAIT  = SW_RECALL_CYC
)(
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire logic              clk_en_in,
    input  wire logic              supply_ok_in,
    input  wire req_t              req_in,
    input  wire logic              req_valid_in,
    output logic                   req_ready_out,
    input  wire logic              soft_cmd_in,
    input  wire logic              soft_recall_in,
    input  wire logic [ADDR_W-1:0] soft_addr_in,
    input  wire logic              hw_store_req_in,
    output logic                   rsp_valid_out,
    output logic [DATA_W-1:0]      rdata_out,
    output logic                   busy_out,
    output mem_pins_t              pins_out,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_out,
    input  wire logic              hw_store_n_in,
    output logic                   hw_store_n_out,
    output logic                   hw_store_n_oe_out
);
    state_t            state_ff;
    logic [WAIT_W-1:0] wait_ff;
    logic [1:0]        cnt_ff;
    req_t              cur_ff;
    logic              soft_ff;
    logic              soft_rec_ff;
    logic [2:0]        seq_ff;
    logic              rsp_ff;
    logic [DATA_W-1:0] rdata_ff;
    mem_pins_t         pins_ff;
    logic              dq_oe_ff;
    logic              pin_pull_ff;

    // soft command is a normal req stream of six reads; supply loss blocks all
    assign req_ready_out     = (state_ff == ST_IDLE) && supply_ok_in;
    assign busy_out          = (state_ff != ST_IDLE);
    assign rsp_valid_out     = rsp_ff;
    assign rdata_out         = rdata_ff;
    assign pins_out          = pins_ff;
    assign dq_out            = cur_ff.wdata;
    assign dq_oe_out         = dq_oe_ff;
    // pin is open drain from our side: we only ever pull it low
    assign hw_store_n_out    = 1'b0;
    assign hw_store_n_oe_out = pin_pull_ff;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_ff     <= ST_PWRUP;
            wait_ff      <= '0;
            cnt_ff       <= 2'h0;
            cur_ff       <= '0;
            soft_ff      <= 1'b0;
            soft_rec_ff  <= 1'b0;
            seq_ff       <= 3'h0;
            rsp_ff       <= 1'b0;
            rdata_ff     <= '0;
            pins_ff      <= '1;
            dq_oe_ff     <= 1'b0;
            pin_pull_ff  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            rsp_ff <= 1'b0;
            unique case (state_ff)
                ST_PWRUP:
                begin
                    // recall runs while supply is up; restart if it dips
                    if (!supply_ok_in)
                        wait_ff <= '0;
                    else if (wait_ff == WAIT_W'(RECALL_WAIT - 1))
                        state_ff <= ST_IDLE;
                    else
                        wait_ff <= wait_ff + 1'b1;
                end
                ST_IDLE:
                begin
                    pins_ff  <= '1;
                    dq_oe_ff <= 1'b0;
                    cnt_ff   <= 2'h0;
                    wait_ff  <= '0;
                    if (!supply_ok_in)
                        state_ff <= ST_PWRUP;
                    else if (hw_store_req_in)
                    begin
                        pin_pull_ff  <= 1'b1;
                        soft_rec_ff  <= 1'b0;
                        state_ff     <= ST_HSTORE;
                    end
                    else if (req_valid_in)
                    begin
                        cur_ff      <= req_in;
                        soft_ff     <= soft_cmd_in;
                        soft_rec_ff <= soft_recall_in;
                        if (soft_cmd_in)
                            cur_ff.write <= 1'b0;
                        // address settles with strobes high; byte enables first
                        pins_ff.addr               <= soft_cmd_in ? soft_addr_in : req_in.addr;
                        pins_ff.low_byte_enable_n  <= ~(req_in.byte_en[0] | req_in.rtc);
                        pins_ff.high_byte_enable_n <= ~req_in.byte_en[1];
                        // write enable settles a cycle before chip enable falls
                        pins_ff.we_n <= ~(req_in.write & ~soft_cmd_in);
                        pins_ff.oe_n <= req_in.write & ~soft_cmd_in;
                        state_ff <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    // chip enable strobes the cycle, write enable already set
                    pins_ff.ce_n <= 1'b0;
                    dq_oe_ff     <= cur_ff.write;
                    state_ff     <= ST_STROBE;
                end
                ST_STROBE:
                begin
                    if (cnt_ff == 2'(ACCESS_CYC - 1))
                    begin
                        rdata_ff     <= dq_in;
                        pins_ff.ce_n <= 1'b1;
                        state_ff     <= ST_GAP;
                    end
                    else
                        cnt_ff <= cnt_ff + 2'h1;
                end
                ST_GAP:
                begin
                    // strobe released before address or write enable moves
                    pins_ff.we_n <= 1'b1;
                    pins_ff.oe_n <= 1'b1;
                    dq_oe_ff     <= 1'b0;
                    rsp_ff       <= 1'b1;
                    if (soft_ff && seq_ff == SEQ_LAST)
                    begin
                        seq_ff   <= 3'h0;
                        state_ff <= ST_LOCK;
                    end
                    else
                    begin
                        seq_ff   <= soft_ff ? seq_ff + 3'h1 : 3'h0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_HSTORE:
                begin
                    // pulse held for STORE_PULSE_CYC + 1 cycles, one more than needed, then let pull-up restore
                    if (cnt_ff == 2'(STORE_PULSE_CYC))
                    begin
                        pin_pull_ff  <= 1'b0;
                        state_ff     <= ST_LOCK;
                    end
                    else
                        cnt_ff <= cnt_ff + 2'h1;
                end
                ST_LOCK:
                begin
                    // worst-case wait; device may skip a store without a write
                    if (wait_ff == WAIT_W'((soft_rec_ff ? SWREC_WAIT : STORE_WAIT)
                                          + SOFT_WAIT - 1))
                    begin
                        // device may still pull the pin low while its store runs
                        if (hw_store_n_in)
                        begin
                            soft_rec_ff <= 1'b0;
                            state_ff    <= ST_IDLE;
                        end
                    end
                    else
                        wait_ff <= wait_ff + 1'b1;
                end
                default: state_ff <= ST_PWRUP;
            endcase
        end
    end

    a_read_we_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!pins_out.ce_n && !pins_out.oe_n) |-> pins_out.we_n)
        else $error("write enable low during read");
    a_addr_stable: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (pins_out.addr != $past(pins_out.addr)) |-> ($past(pins_out.ce_n) && pins_out.ce_n))
        else $error("address moved while selected");
    a_we_before_ce: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(pins_out.ce_n) |-> $stable(pins_out.we_n))
        else $error("write enable moved with chip enable");
    a_hsb_idle_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !pins_out.ce_n |-> !hw_store_n_oe_out)
        else $error("store pin driven during cycle");
    a_ble_first: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && $fell(pins_out.ce_n) && cur_ff.rtc) |-> $past(!pins_out.low_byte_enable_n))
        else $error("low byte enable late for clock write");
    a_lock_no_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == ST_LOCK || state_ff == ST_PWRUP) |-> (pins_out.ce_n && !req_ready_out))
        else $error("cycle during lockout");
    a_hsb_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && $rose(hw_store_n_oe_out)) |-> ##[1:8] !hw_store_n_oe_out)
        else $error("store pin held too long");
    a_gap_rsp: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && state_ff == ST_GAP && !soft_ff) |=> (rsp_valid_out && state_ff == ST_IDLE))
        else $error("cycle did not return to idle");
    a_dq_read_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!pins_out.ce_n && pins_out.we_n) |-> !dq_oe_out)
        else $error("data driven during read");
    a_soft_reads: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (soft_ff && !pins_out.ce_n) |-> pins_out.we_n)
        else $error("write enable low in soft sequence");
    a_byte_en_held: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !pins_out.ce_n |-> $stable({pins_out.low_byte_enable_n, pins_out.high_byte_enable_n}))
        else $error("byte enables moved while selected");
    a_store_pin_free: assert property (@(posedge core_clk_in) disable iff (rst_in)
        hw_store_n_oe_out |-> (state_ff == ST_HSTORE))
        else $error("store pin pulled outside store");
endmodule
`default_nettype wire

//--- core/nv_host_pkg.sv
// constants and types for the nvsram host controller
package nv_host_pkg;
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned ADDR_W         = 19;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned RECALL_MS      = 20;
    localparam int unsigned STORE_MS       = 8;
    localparam int unsigned SOFT_SEQ_US    = 100;
    localparam int unsigned SW_RECALL_US   = 200;
    localparam int unsigned RECALL_CYC     = RECALL_MS * 1000 * CLK_MHZ;
    localparam int unsigned STORE_CYC      = STORE_MS * 1000 * CLK_MHZ;
    localparam int unsigned SOFT_SEQ_CYC   = SOFT_SEQ_US * CLK_MHZ;
    localparam int unsigned SW_RECALL_CYC  = SW_RECALL_US * CLK_MHZ;
    localparam int unsigned ACCESS_NS      = 45;
    localparam int unsigned CLK_NS         = 25;
    localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned STORE_PULSE_NS  = 15;
    localparam int unsigned STORE_PULSE_CYC = (STORE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SEQ_LEN        = 6;
    localparam int unsigned WAIT_W         = 24;
    localparam logic [2:0]  SEQ_LAST       = 3'h5;

    typedef struct packed {
        logic              write;
        logic              rtc;
        logic [1:0]        byte_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic              low_byte_enable_n;
        logic              high_byte_enable_n;
        logic [ADDR_W-1:0] addr;
    } mem_pins_t;

    typedef enum logic [2:0] {
        ST_PWRUP  = 3'b000,
        ST_IDLE   = 3'b001,
        ST_SETUP  = 3'b010,
        ST_STROBE = 3'b011,
        ST_GAP    = 3'b100,
        ST_HSTORE = 3'b101,
        ST_LOCK   = 3'b110
    } state_t;
endpackage

//--- tb/nv_sram_model.sv
// behavioural model of the nonvolatile sram, device side of the pins
`timescale 1ns/1ps
`default_nettype none
module nv_sram_model
    import nv_host_pkg::*;
#(
    parameter int unsigned RECALL_NS = 500,
    parameter int unsigned STORE_NS  = 400
)(
    input  wire logic              supply_ok_in,
    input  wire mem_pins_t         pins_in,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              hw_store_n_in,
    output logic [DATA_W-1:0]      dq_out
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] last     = '0;
    logic              locked   = 1'b1;
    logic              dirty    = 1'b0;
    logic              we_at_ce = 1'b0;
    int                n_soft   = 0;
    wire logic wr_act  = !pins_in.ce_n && !pins_in.we_n;
    wire logic rd_act  = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n && !we_at_ce;
    wire logic io_open = !locked && supply_ok_in;
    always @(negedge pins_in.ce_n) we_at_ce = !pins_in.we_n;
    always @(negedge supply_ok_in) locked = 1'b1;
    always @(posedge supply_ok_in)
    begin
        locked = 1'b1;
        #(RECALL_NS) locked = 1'b0;
    end
    always @(negedge wr_act)
        if (io_open)
        begin
            word = mem.exists(int'(pins_in.addr)) ? mem[int'(pins_in.addr)] : '0;
            if (!pins_in.low_byte_enable_n) word[7:0] = dq_in[7:0];
            if (!pins_in.high_byte_enable_n) word[15:8] = dq_in[15:8];
            mem[int'(pins_in.addr)] = word;
            dirty = 1'b1;
            n_soft = 0;
        end
    // soft sequence reads sit in the top sixteen words only
    always @(negedge rd_act)
        if (io_open)
        begin
            n_soft = (&pins_in.addr[ADDR_W-1:4]) ? n_soft + 1 : 0;
            if (n_soft == SEQ_LEN)
            begin
                n_soft = 0;
                #(STORE_NS / 4) locked = 1'b1;
                #(STORE_NS) locked = 1'b0;
            end
        end
    always @(negedge hw_store_n_in)
        if (dirty && io_open)
        begin
            #20 locked = 1'b1;
            dirty = 1'b0;
            #(STORE_NS) locked = 1'b0;
        end
    // a released bus never repeats the last word
    always @(pins_in or locked or supply_ok_in or we_at_ce or last or rd_act)
        if (rd_act && io_open)
        begin
            dq_out = mem.exists(int'(pins_in.addr)) ? mem[int'(pins_in.addr)] : '0;
            last = dq_out;
        end
        else
            dq_out = ~last;
endmodule
`default_nettype wire

//--- tb/tb_nv_host_ctrl.sv
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_nv_host_ctrl
    import nv_host_pkg::*;
;
    localparam int unsigned RW = 40;
    localparam int unsigned SW = 30;
    localparam int unsigned FW = 20;
    localparam int unsigned XW = 40;
    logic              core_clk_in = 1'b0;
    logic              rst_in      = 1'b1;
    logic              supply_ok   = 1'b0;
    logic              req_valid   = 1'b0;
    logic              soft_cmd    = 1'b0;
    logic              soft_rec    = 1'b0;
    logic              hs_req      = 1'b0;
    req_t              req         = '0;
    logic [ADDR_W-1:0] soft_addr   = '0;
    logic              ready, rsp_valid, busy, dq_oe, store_pin_drv, store_pin_oe;
    logic [DATA_W-1:0] rdata, dq_host, dq_dev;
    mem_pins_t         pins, prev;
    wire logic         store_pin = store_pin_oe ? store_pin_drv : 1'b1;
    int                n_mismatch  = 0;
    int                check_count = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    nv_host_ctrl #(
        .RECALL_WAIT(RW), .STORE_WAIT(SW), .SOFT_WAIT(FW), .SWREC_WAIT(XW)
    ) u_nv_host_ctrl (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'b1), .supply_ok_in(supply_ok),
        .req_in(req), .req_valid_in(req_valid), .req_ready_out(ready), .soft_cmd_in(soft_cmd),
        .soft_recall_in(soft_rec), .soft_addr_in(soft_addr), .hw_store_req_in(hs_req),
        .rsp_valid_out(rsp_valid), .rdata_out(rdata), .busy_out(busy), .pins_out(pins),
        .dq_in(dq_dev), .dq_out(dq_host), .dq_oe_out(dq_oe), .hw_store_n_in(store_pin),
        .hw_store_n_out(store_pin_drv), .hw_store_n_oe_out(store_pin_oe));
    nv_sram_model u_nv_sram_model (
        .supply_ok_in(supply_ok), .pins_in(pins), .dq_in(dq_host), .hw_store_n_in(store_pin),
        .dq_out(dq_dev));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 400)
        begin
            @(posedge core_clk_in);
            n++;
        end
    endtask
    task automatic xfer(input logic wr, input logic rtc, input logic [1:0] be,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic sc);
        int n;
        req <= '{write: wr, rtc: rtc, byte_en: be, addr: a, wdata: d};
        soft_cmd <= sc;
        soft_addr <= a;
        req_valid <= 1'b1;
        @(posedge core_clk_in);
        wait_ready(n);
        req_valid <= 1'b0;
        soft_cmd <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(posedge core_clk_in);
            n++;
        end
        check("rsp_seen", 32'(n < 20), 1);
    endtask
    task automatic t_rw;
        xfer(1'b1, 1'b0, 2'h3, 19'h00012, 16'ha5c3, 1'b0);
        xfer(1'b1, 1'b0, 2'h1, 19'h00013, 16'h1234, 1'b0);
        xfer(1'b1, 1'b1, 2'h2, 19'h00020, 16'hbeef, 1'b0);
        xfer(1'b0, 1'b0, 2'h3, 19'h00012, 16'h0000, 1'b0);
        check("rd_full", rdata, 16'ha5c3);
        xfer(1'b0, 1'b0, 2'h3, 19'h00013, 16'h0000, 1'b0);
        check("rd_lane", rdata, 16'h0034);
        xfer(1'b0, 1'b0, 2'h3, 19'h00020, 16'h0000, 1'b0);
        check("rtc_word", rdata, 16'hbeef);
    endtask
    task automatic t_hstore;
        int n;
        hs_req <= 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 10)
        begin
            @(posedge core_clk_in);
            n++;
        end
        hs_req <= 1'b0;
        check("store_pull", store_pin, 0);
        wait_ready(n);
        check("store_lock", 32'(n >= SW + FW && n <= SW + FW + 4), 1);
        check("store_release", store_pin, 1);
        xfer(1'b0, 1'b0, 2'h3, 19'h00012, 16'h0000, 1'b0);
        check("after_store", rdata, 16'ha5c3);
    endtask
    task automatic t_soft(input logic rec);
        int n;
        soft_rec <= rec;
        for (int i = 0; i < SEQ_LEN; i++)
            xfer(1'b0, 1'b0, 2'h3, 19'h7fff0 + 19'(i), 16'h0000, 1'b1);
        wait_ready(n);
        soft_rec <= 1'b0;
        check("soft_lock", 32'(n >= (rec ? XW : SW) + FW && n <= (rec ? XW : SW) + FW + 1), 1);
        xfer(1'b0, 1'b0, 2'h3, 19'h00013, 16'h0000, 1'b0);
        check("after_soft", rdata, 16'h0034);
    endtask
    task automatic t_supply;
        int n;
        supply_ok <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        check("low_supply", ready, 0);
        supply_ok <= 1'b1;
        @(posedge core_clk_in);
        wait_ready(n);
        check("re_recall", 32'(n >= RW && n <= RW + 1), 1);
    endtask
    always @(posedge core_clk_in)
    begin
        if (!rst_in && !pins.ce_n)
        begin
            check("store_pin", store_pin, 1);
            check("dq_dir", dq_oe, !pins.we_n);
            if (!pins.oe_n)
                check("we_in_read", pins.we_n, 1);
            if (!prev.ce_n && !prev.we_n)
                check("addr_hold", pins.addr, prev.addr);
            if (prev.ce_n && !pins.we_n)
                check("we_first", {prev.we_n, req.rtc & prev.low_byte_enable_n}, 0);
        end
        prev <= pins;
    end
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_supply();
        t_rw();
        t_hstore();
        t_soft(1'b0);
        t_soft(1'b1);
        t_supply();
        conclude();
    end
    initial
    begin
        #(4000 * 25);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
